// ---- rtl/loop_status_pkg.sv ----
/*
 Constants of the loop and status register bank: word offsets, field masks, reset values.
 Assumes a 16-bit word-addressed register port and a 24-bit program address space.
*/
package loop_status_pkg;
   // ***********************
   // word offsets
   // ***********************
   localparam logic [7:0] OFF_ST0       = 8'h02;
   localparam logic [7:0] OFF_ST1       = 8'h03;
   localparam logic [7:0] OFF_ST3       = 8'h04;
   localparam logic [7:0] OFF_ST0_PROT  = 8'h06;
   localparam logic [7:0] OFF_ST1_PROT  = 8'h07;
   localparam logic [7:0] OFF_ST3_PROT  = 8'h1D;
   localparam logic [7:0] OFF_ST2       = 8'h4B;
   localparam logic [7:0] OFF_OCNT      = 8'h1A;
   localparam logic [7:0] OFF_ISAVE     = 8'h1B;
   localparam logic [7:0] OFF_ICNT      = 8'h39;
   localparam logic [7:0] OFF_OSTART_HI = 8'h3C;
   localparam logic [7:0] OFF_OSTART_LO = 8'h3D;
   localparam logic [7:0] OFF_OEND_HI   = 8'h3E;
   localparam logic [7:0] OFF_OEND_LO   = 8'h3F;
   localparam logic [7:0] OFF_ISTART_HI = 8'h40;
   localparam logic [7:0] OFF_ISTART_LO = 8'h41;
   localparam logic [7:0] OFF_IEND_HI   = 8'h42;
   localparam logic [7:0] OFF_IEND_LO   = 8'h43;
   // ***********************
   // status fields
   // ***********************
   localparam logic [15:0] ST0_RESET = 16'h3800;
   localparam logic [15:0] ST1_RESET = 16'h2920;
   localparam logic [15:0] ST2_RESET = 16'h7000;
   localparam logic [15:0] ST3_RESET = 16'h1C00;
   localparam logic [15:0] ST0_PROT  = 16'hE000;
   localparam logic [15:0] ST1_PROT  = 16'h0420;
   localparam logic [15:0] ST3_PROT  = 16'hF0A0;
   localparam logic [15:0] ST2_WMASK = 16'h9DFF;
   localparam logic [15:0] ST3_WMASK = 16'hF0E7;
   localparam logic [15:0] ST3_CACHE = 16'hE000;
   localparam logic [15:0] ST3_FIXED = 16'h0C00;
   localparam int LOOP_ACTIVE_FLAG_POS   = 15;
   localparam int COMPAT_POS = 5;
   localparam int MICROPROCESSOR_MODE_BIT_POS  = 6;
   localparam logic [1:0] STRAP_LOAD = 2'h2;
endpackage

// ---- rtl/loop_status_bank.sv ----
/*
 Block-repeat loop registers and the four status words of the core.
 Assumes the sequencer pulses instr_valid per executed instruction and repeat_start per decoded
 block repeat; mode_pin is asynchronous and is sampled after reset release.
*/
// The strobed register port is this design's own decision.
module loop_status_bank #(
   parameter bit HAS_CACHE = 1'b1,
   parameter int CNT_W     = 16,
   parameter int PA_W      = 24
) (
   input  wire logic             clk_sys,
   input  wire logic             sys_rst,
   input  wire logic [7:0]       reg_addr,
   input  wire logic [15:0]      reg_wdata,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   output logic      [15:0]      reg_rdata,
   input  wire logic             mode_pin,
   input  wire logic             instr_valid,
   input  wire logic [PA_W-1:0]  instr_addr,
   input  wire logic             repeat_start,
   input  wire logic [PA_W-1:0]  repeat_first,
   input  wire logic [PA_W-1:0]  repeat_last,
   output logic                  branch_taken,
   output logic      [PA_W-1:0]  branch_target,
   output logic                  outer_active,
   output logic                  inner_active,
   output logic      [15:0]      status_word_zero,
   output logic      [15:0]      status_word_one,
   output logic      [15:0]      status_word_two,
   output logic      [15:0]      status_word_three
);
   // ***********************
   // helpers
   // ***********************
   // merge write data under a mask
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                         input logic [15:0] m);
      merge = (old & ~m) | (wd & m);
   endfunction

   // read 24-bit register as high or low word
   function automatic logic [15:0] half(input logic [PA_W-1:0] r, input logic hi);
      half = hi ? {8'h00, r[23:16]} : r[15:0];
   endfunction

   // 24-bit register after a word write
   function automatic logic [PA_W-1:0] put(input logic [PA_W-1:0] r, input logic hi,
                                           input logic [15:0] wd);
      put = hi ? {wd[7:0], r[15:0]} : {r[23:16], wd};
   endfunction

   localparam logic [15:0] ST3_W = HAS_CACHE ? loop_status_pkg::ST3_WMASK
                                             : (loop_status_pkg::ST3_WMASK & ~loop_status_pkg::ST3_CACHE);

   logic [CNT_W-1:0] outer_loop_counter;
   logic [CNT_W-1:0] inner_loop_counter;
   logic [CNT_W-1:0] inner_count_save;
   logic [PA_W-1:0]  outer_loop_start_address;
   logic [PA_W-1:0]  outer_loop_end_address;
   logic [PA_W-1:0]  inner_loop_start_address;
   logic [PA_W-1:0]  inner_loop_end_address;
   logic             mode_meta;
   logic             mode_sync;
   logic [1:0]       strap_cnt;

   // ***********************
   // decode
   // ***********************
   logic compat;
   logic w_ocnt, w_icnt, w_isave;
   logic w_st0, w_st1, w_st2, w_st3, p_st0, p_st1, p_st3;
   logic start_inner, start_outer, inner_hit, outer_hit;
   logic inner_nz, outer_nz;

   // write strobes per register; alias strobes separate
   assign compat  = status_word_one[loop_status_pkg::COMPAT_POS];
   assign w_ocnt  = reg_wr && reg_addr == loop_status_pkg::OFF_OCNT;
   assign w_icnt  = reg_wr && reg_addr == loop_status_pkg::OFF_ICNT;
   assign w_isave = reg_wr && reg_addr == loop_status_pkg::OFF_ISAVE;
   assign w_st0   = reg_wr && reg_addr == loop_status_pkg::OFF_ST0;
   assign w_st1   = reg_wr && reg_addr == loop_status_pkg::OFF_ST1;
   assign w_st2   = reg_wr && reg_addr == loop_status_pkg::OFF_ST2;
   assign w_st3   = reg_wr && reg_addr == loop_status_pkg::OFF_ST3;
   assign p_st0   = reg_wr && reg_addr == loop_status_pkg::OFF_ST0_PROT;
   assign p_st1   = reg_wr && reg_addr == loop_status_pkg::OFF_ST1_PROT;
   assign p_st3   = reg_wr && reg_addr == loop_status_pkg::OFF_ST3_PROT;

   // level choice: inner only in native mode inside an active outer loop
   assign start_inner = repeat_start && !compat && outer_active;
   assign start_outer = repeat_start && !start_inner;
   assign inner_nz    = inner_loop_counter != '0;
   assign outer_nz    = outer_loop_counter != '0;
   // end-of-block detection, inner level first
   assign inner_hit = instr_valid && inner_active && !compat
                      && instr_addr == inner_loop_end_address;
   assign outer_hit = instr_valid && outer_active && !inner_hit
                      && instr_addr == outer_loop_end_address;

   // ***********************
   // loop counters
   // ***********************
   // outer counter: software load, else decrement on taken branch
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         outer_loop_counter <= '0;
      end else if (w_ocnt) begin
         outer_loop_counter <= reg_wdata[CNT_W-1:0];
      end else if (outer_hit && outer_nz) begin
         outer_loop_counter <= outer_loop_counter - CNT_W'(1);
      end
   end

   // inner counter: software load, reload from save at start, decrement
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         inner_loop_counter <= '0;
      end else if (w_icnt) begin
         inner_loop_counter <= reg_wdata[CNT_W-1:0];
      end else if (start_inner) begin
         inner_loop_counter <= inner_count_save;
      end else if (inner_hit && inner_nz) begin
         inner_loop_counter <= inner_loop_counter - CNT_W'(1);
      end
   end

   // save register follows every counter load; direct writes are dropped while the inner loop is active
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         inner_count_save <= '0;
      end else if (w_icnt) begin
         inner_count_save <= reg_wdata[CNT_W-1:0];
      end else if (w_isave && !inner_active) begin
         inner_count_save <= reg_wdata[CNT_W-1:0];
      end
   end

   // ***********************
   // address registers
   // ***********************
   // outer start and end: repeat instruction or software word writes
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         outer_loop_start_address <= '0;
         outer_loop_end_address   <= '0;
      end else if (start_outer) begin
         outer_loop_start_address <= repeat_first;
         outer_loop_end_address   <= repeat_last;
      end else if (reg_wr) begin
         case (reg_addr)
            loop_status_pkg::OFF_OSTART_HI: begin
               outer_loop_start_address <= put(outer_loop_start_address, 1'b1, reg_wdata);
            end
            loop_status_pkg::OFF_OSTART_LO: begin
               outer_loop_start_address <= put(outer_loop_start_address, 1'b0, reg_wdata);
            end
            loop_status_pkg::OFF_OEND_HI: begin
               outer_loop_end_address <= put(outer_loop_end_address, 1'b1, reg_wdata);
            end
            loop_status_pkg::OFF_OEND_LO: begin
               outer_loop_end_address <= put(outer_loop_end_address, 1'b0, reg_wdata);
            end
            default: begin
            end
         endcase
      end
   end

   // inner start and end
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         inner_loop_start_address <= '0;
         inner_loop_end_address   <= '0;
      end else if (start_inner) begin
         inner_loop_start_address <= repeat_first;
         inner_loop_end_address   <= repeat_last;
      end else if (reg_wr) begin
         case (reg_addr)
            loop_status_pkg::OFF_ISTART_HI: begin
               inner_loop_start_address <= put(inner_loop_start_address, 1'b1, reg_wdata);
            end
            loop_status_pkg::OFF_ISTART_LO: begin
               inner_loop_start_address <= put(inner_loop_start_address, 1'b0, reg_wdata);
            end
            loop_status_pkg::OFF_IEND_HI: begin
               inner_loop_end_address <= put(inner_loop_end_address, 1'b1, reg_wdata);
            end
            loop_status_pkg::OFF_IEND_LO: begin
               inner_loop_end_address <= put(inner_loop_end_address, 1'b0, reg_wdata);
            end
            default: begin
            end
         endcase
      end
   end

   // ***********************
   // loop sequencing
   // ***********************
   // level activity; clearing the active flag in compat mode stops the loop
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         outer_active <= 1'b0;
         inner_active <= 1'b0;
      end else begin
         if (start_outer) begin
            outer_active <= 1'b1;
         end else if (outer_hit && !outer_nz) begin
            outer_active <= 1'b0;
         end else if (compat && (w_st1 || p_st1) && !reg_wdata[loop_status_pkg::LOOP_ACTIVE_FLAG_POS]) begin
            outer_active <= 1'b0;
         end
         if (start_inner) begin
            inner_active <= 1'b1;
         end else if ((inner_hit && !inner_nz) || compat) begin
            inner_active <= 1'b0;
         end
      end
   end

   // branch back request to the fetch unit, one cycle after the end address
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         branch_taken  <= 1'b0;
         branch_target <= '0;
      end else begin
         branch_taken  <= (inner_hit && inner_nz) || (outer_hit && outer_nz);
         branch_target <= inner_hit ? inner_loop_start_address : outer_loop_start_address;
      end
   end

   // ***********************
   // status words
   // ***********************
   // word zero: protected alias keeps designated bits
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         status_word_zero <= loop_status_pkg::ST0_RESET;
      end else if (w_st0) begin
         status_word_zero <= reg_wdata;
      end else if (p_st0) begin
         status_word_zero <= merge(status_word_zero, reg_wdata, ~loop_status_pkg::ST0_PROT);
      end
   end

   // word one: hardware setting of the active flag wins over software
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         status_word_one <= loop_status_pkg::ST1_RESET;
      end else begin
         if (w_st1) begin
            status_word_one <= reg_wdata;
         end else if (p_st1) begin
            status_word_one <= merge(status_word_one, reg_wdata, ~loop_status_pkg::ST1_PROT);
         end
         if (compat && start_outer) begin
            status_word_one[loop_status_pkg::LOOP_ACTIVE_FLAG_POS] <= 1'b1;
         end else if (compat && outer_hit && !outer_nz) begin
            status_word_one[loop_status_pkg::LOOP_ACTIVE_FLAG_POS] <= 1'b0;
         end
      end
   end

   // word two: reserved positions stay at their fixed value
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         status_word_two <= loop_status_pkg::ST2_RESET;
      end else if (w_st2) begin
         status_word_two <= merge(status_word_two, reg_wdata, loop_status_pkg::ST2_WMASK);
      end
   end

   // strap pin synchroniser and delayed capture counter
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         mode_meta <= 1'b0;
         mode_sync <= 1'b0;
         strap_cnt <= 2'h0;
      end else begin
         mode_meta <= mode_pin;
         mode_sync <= mode_meta;
         if (strap_cnt != 2'h3) begin
            strap_cnt <= strap_cnt + 2'h1;
         end
      end
   end

   // word three: fixed reserved field, cache bits gated by build option
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         status_word_three <= loop_status_pkg::ST3_RESET;
      end else if (strap_cnt == loop_status_pkg::STRAP_LOAD) begin
         status_word_three[loop_status_pkg::MICROPROCESSOR_MODE_BIT_POS] <= mode_sync;
      end else if (w_st3) begin
         status_word_three <= merge(status_word_three, reg_wdata, ST3_W) | loop_status_pkg::ST3_FIXED;
      end else if (p_st3) begin
         status_word_three <= merge(status_word_three, reg_wdata, ST3_W & ~loop_status_pkg::ST3_PROT);
      end
   end

   // ***********************
   // read port
   // ***********************
   // read data one cycle after the strobe, zero otherwise
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         case (reg_addr)
            loop_status_pkg::OFF_ST0:       reg_rdata <= status_word_zero;
            loop_status_pkg::OFF_ST1:       reg_rdata <= status_word_one;
            loop_status_pkg::OFF_ST2:       reg_rdata <= status_word_two;
            loop_status_pkg::OFF_ST3:       reg_rdata <= status_word_three;
            loop_status_pkg::OFF_ST0_PROT:  reg_rdata <= status_word_zero & ~loop_status_pkg::ST0_PROT;
            loop_status_pkg::OFF_ST1_PROT:  reg_rdata <= status_word_one & ~loop_status_pkg::ST1_PROT;
            loop_status_pkg::OFF_ST3_PROT:  reg_rdata <= status_word_three & ~loop_status_pkg::ST3_PROT;
            loop_status_pkg::OFF_OCNT:      reg_rdata <= 16'(outer_loop_counter);
            loop_status_pkg::OFF_ICNT:      reg_rdata <= 16'(inner_loop_counter);
            loop_status_pkg::OFF_ISAVE:     reg_rdata <= 16'(inner_count_save);
            loop_status_pkg::OFF_OSTART_HI: reg_rdata <= half(outer_loop_start_address, 1'b1);
            loop_status_pkg::OFF_OSTART_LO: reg_rdata <= half(outer_loop_start_address, 1'b0);
            loop_status_pkg::OFF_OEND_HI:   reg_rdata <= half(outer_loop_end_address, 1'b1);
            loop_status_pkg::OFF_OEND_LO:   reg_rdata <= half(outer_loop_end_address, 1'b0);
            loop_status_pkg::OFF_ISTART_HI: reg_rdata <= half(inner_loop_start_address, 1'b1);
            loop_status_pkg::OFF_ISTART_LO: reg_rdata <= half(inner_loop_start_address, 1'b0);
            loop_status_pkg::OFF_IEND_HI:   reg_rdata <= half(inner_loop_end_address, 1'b1);
            loop_status_pkg::OFF_IEND_LO:   reg_rdata <= half(inner_loop_end_address, 1'b0);
            default:                        reg_rdata <= 16'h0000;
         endcase
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

   // ***********************
   // assertions
   // ***********************
   property p_save_follow;
      @(posedge clk_sys) disable iff (sys_rst)
      w_icnt |=> inner_count_save == $past(reg_wdata);
   endproperty
   a_save_follow: assert property (p_save_follow) else $error("save missed counter load");

   property p_save_hold;
      @(posedge clk_sys) disable iff (sys_rst)
      inner_active && !w_icnt |=> $stable(inner_count_save);
   endproperty
   a_save_hold: assert property (p_save_hold) else $error("save changed in inner loop");

   property p_reload;
      @(posedge clk_sys) disable iff (sys_rst)
      start_inner && !w_icnt |=> inner_loop_counter == $past(inner_count_save) && inner_active;
   endproperty
   a_reload: assert property (p_reload) else $error("inner counter not reloaded");

   property p_compat_inner;
      @(posedge clk_sys) disable iff (sys_rst)
      compat && repeat_start |=> !inner_active && outer_active;
   endproperty
   a_compat_inner: assert property (p_compat_inner) else $error("inner level used in compat");

   property p_prot_read;
      @(posedge clk_sys) disable iff (sys_rst)
      reg_rd && reg_addr == loop_status_pkg::OFF_ST3_PROT |=> (reg_rdata & loop_status_pkg::ST3_PROT) == 16'h0000;
   endproperty
   a_prot_read: assert property (p_prot_read) else $error("protected bit visible");

   property p_prot_write;
      @(posedge clk_sys) disable iff (sys_rst)
      p_st0 |=> (status_word_zero & loop_status_pkg::ST0_PROT) == $past(status_word_zero & loop_status_pkg::ST0_PROT);
   endproperty
   a_prot_write: assert property (p_prot_write) else $error("protected bit written");

   property p_hi_word;
      @(posedge clk_sys) disable iff (sys_rst)
      reg_wr && reg_addr == loop_status_pkg::OFF_OSTART_HI && !start_outer ##1 reg_rd
      && reg_addr == loop_status_pkg::OFF_OSTART_HI && !start_outer |=> reg_rdata == {8'h00, $past(reg_wdata[7:0], 2)};
   endproperty
   a_hi_word: assert property (p_hi_word) else $error("high address word wrong");

   property p_branch;
      @(posedge clk_sys) disable iff (sys_rst)
      outer_hit && outer_nz && !w_ocnt |=> branch_taken && branch_target == $past(outer_loop_start_address)
      && outer_loop_counter == $past(outer_loop_counter) - CNT_W'(1);
   endproperty
   a_branch: assert property (p_branch) else $error("loop branch wrong");

   property p_fall;
      @(posedge clk_sys) disable iff (sys_rst)
      outer_hit && !outer_nz && !start_outer |=> !branch_taken && !outer_active;
   endproperty
   a_fall: assert property (p_fall) else $error("no fall through");

   property p_reserved;
      @(posedge clk_sys) disable iff (sys_rst)
      (status_word_three & ~ST3_W) == (loop_status_pkg::ST3_FIXED & ~ST3_W) || strap_cnt < 2'h3;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits changed");

   property p_loop_active_flag;
      @(posedge clk_sys) disable iff (sys_rst)
      compat && start_outer |=> status_word_one[loop_status_pkg::LOOP_ACTIVE_FLAG_POS];
   endproperty
   a_loop_active_flag: assert property (p_loop_active_flag) else $error("active flag not set");

   c_nested: cover property (@(posedge clk_sys) disable iff (sys_rst) start_inner ##[1:50] inner_hit);
   c_outer_loop: cover property (@(posedge clk_sys) disable iff (sys_rst) outer_hit && outer_nz);
   c_compat_exit: cover property (@(posedge clk_sys) disable iff (sys_rst) compat && outer_hit && !outer_nz);
endmodule

// ---- tb/loop_status_bank_tb.sv ----
/*
 Self-checking bench of the loop and status register bank: reset values, split
 addresses, protected aliases, fixed status fields, one outer loop and one nested loop.
 Assumes a read answers one cycle after its strobe and mode_pin is held high.
*/
module loop_status_bank_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys = 1'b0;
   logic        sys_rst = 1'b1;
   logic [7:0]  reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        instr_valid = 1'b0;
   logic        repeat_start = 1'b0;
   logic [23:0] instr_addr = 24'h000000;
   logic        mode_pin = 1'b1;
   logic [23:0] repeat_first = 24'h000100;
   logic [23:0] repeat_last = 24'h000104;
   logic [15:0] reg_rdata, st0, st1, st2, st3;
   logic        branch_taken, outer_active, inner_active;
   logic [23:0] branch_target;
   int          miscompares = 0;
   int          check_count = 0;
   // free-running core clock
   always #25 clk_sys = ~clk_sys;
   loop_status_bank loop_status_bank_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mode_pin(mode_pin),
      .instr_valid(instr_valid), .instr_addr(instr_addr), .repeat_start(repeat_start),
      .repeat_first(repeat_first), .repeat_last(repeat_last), .branch_taken(branch_taken),
      .branch_target(branch_target), .outer_active(outer_active), .inner_active(inner_active),
      .status_word_zero(st0), .status_word_one(st1), .status_word_two(st2), .status_word_three(st3));
   // ***********************
   // bus and compare tasks
   // ***********************
   task chk(input logic [23:0] got, input logic [23:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      #1;
      chk({8'h00, reg_rdata}, {8'h00, exp});
   endtask
   // write immediately followed by a read of the same word
   task wr_rd(input logic [7:0] a, input logic [15:0] d, input logic [15:0] exp);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b1;
      @(posedge clk_sys);
      reg_rd    <= 1'b0;
      #1;
      chk({8'h00, reg_rdata}, {8'h00, exp});
   endtask
   // one decoded block repeat over the block f to l
   task start_rep(input logic [23:0] f, input logic [23:0] l);
      @(posedge clk_sys);
      repeat_start <= 1'b1;
      repeat_first <= f;
      repeat_last  <= l;
      @(posedge clk_sys);
      repeat_start <= 1'b0;
      #1;
   endtask
   // one executed instruction at address a
   task hit(input logic [23:0] a);
      @(posedge clk_sys);
      instr_valid <= 1'b1;
      instr_addr  <= a;
      @(posedge clk_sys);
      instr_valid <= 1'b0;
      #1;
   endtask
   // ***********************
   // scenarios
   // ***********************
   task check_reset;
      chk({8'h00, st0}, {8'h00, loop_status_pkg::ST0_RESET});
      chk({8'h00, st1}, {8'h00, loop_status_pkg::ST1_RESET});
      chk({8'h00, st2}, {8'h00, loop_status_pkg::ST2_RESET});
      chk({8'h00, st3}, 24'h001C40);
   endtask
   task check_split;
      wr_rd(8'h3C, 16'hAB12, 16'h0012);
      wr(8'h3D, 16'h3456);
      rd(8'h3D, 16'h3456);
      wr(8'h42, 16'h00FE);
      rd(8'h42, 16'h00FE);
      rd(8'h00, 16'h0000);
   endtask
   task check_status;
      wr(8'h06, 16'hFFFF);
      rd(8'h06, 16'h1FFF);
      rd(8'h02, 16'h3FFF);
      wr(8'h1D, 16'hFCE7);
      rd(8'h1D, 16'h0C47);
      wr(8'h04, 16'hFCE7);
      rd(8'h04, 16'hFCE7);
      wr(8'h4B, 16'h0000);
      rd(8'h4B, 16'h6000);
      wr(8'h39, 16'h0005);
      rd(8'h1B, 16'h0005);
   endtask
   task check_loop;
      wr(8'h1A, 16'h0001);
      start_rep(24'h000100, 24'h000104);
      chk({23'h0, outer_active}, 24'h000001);
      hit(24'h000104);
      chk({23'h0, branch_taken}, 24'h000001);
      chk(branch_target, 24'h000100);
      hit(24'h000104);
      chk({23'h0, branch_taken}, 24'h000000);
      @(posedge clk_sys);
      #1;
      chk({23'h0, outer_active}, 24'h000000);
      rd(8'h1A, 16'h0000);
   endtask
   // native mode: a repeat inside the running outer loop takes the inner level
   task check_nested;
      wr(8'h03, 16'h2900);
      wr(8'h39, 16'h0001);
      start_rep(24'h000100, 24'h000104);
      start_rep(24'h000101, 24'h000103);
      chk({23'h0, inner_active}, 24'h000001);
      hit(24'h000103);
      chk({23'h0, branch_taken}, 24'h000001);
      chk(branch_target, 24'h000101);
      hit(24'h000103);
      chk({23'h0, inner_active}, 24'h000000);
      start_rep(24'h000101, 24'h000103);
      rd(8'h39, 16'h0001);
      wr(8'h1B, 16'h0007);
      rd(8'h1B, 16'h0001);
      rd(8'h43, 16'h0103);
      hit(24'h000103);
      hit(24'h000103);
      hit(24'h000104);
      chk({23'h0, outer_active}, 24'h000000);
   endtask
   task wrap_up;
      $display("Checks %0d, miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // reset, then every scenario in turn
   initial begin
      repeat (16) @(posedge clk_sys);
      sys_rst <= 1'b0;
      repeat (4) @(posedge clk_sys);
      #1;
      check_reset();
      check_split();
      check_status();
      check_loop();
      check_nested();
      wrap_up();
   end
endmodule
